// ==== hdl/ddu_regs.svh ====
`ifndef DDU_REGS_SVH
`define DDU_REGS_SVH

// What this block does
// - frame select fall starts a new frame
// - under 24 edges: frame dropped, nothing written
// - over 24 edges standalone: frame dropped
// - frame select rise moves word to target
// - bits past 24 ripple out serially
// - serial output changes on rising clock edge
// - frame select high freezes shift register
// - output disable bit gates serial output, resets zero
// - read frame writes nothing, selects readback
// - next frame shifts out selected register
// - fine gain reads back in six bits
// - load pin low: update at frame end
// - load pin high: hold, fall updates both
// - coding maps code to linear ladder step
// - msb first, field layout, bit 22 zero
// - register type codes per field
// - coding select pin picks data coding

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define DDU_CNT_W      5
`define DDU_CNT_FULL   5'h18
`define DDU_CNT_MAX    5'h1F
`define DDU_CNT_ONE    5'h01
`define DDU_BIT_RW     23
`define DDU_BIT_ZERO   22
`define DDU_REG_HI     21
`define DDU_REG_LO     19
`define DDU_CH_HI      18
`define DDU_CH_LO      16
`define DDU_DATA_HI    15

// ------------------------------------------------------------
// register contents
// ------------------------------------------------------------
`define DDU_FINE_W     6
`define DDU_FUNC_W     6
`define DDU_FUNC_OFF   0
`define DDU_AUX_HI     5
`define DDU_AUX_LO     1
`define DDU_ZERO_CODE  16'h0000
`define DDU_SIGN_FLIP  16'h8000
`define DDU_RB_PAD     8'h00

`endif

// ==== hdl/ddu_pkg.sv ====
package ddu_pkg;

	typedef enum logic [2:0] {
		rt_func   = 3'b000,
		rt_data   = 3'b010,
		rt_coarse = 3'b011,
		rt_fine   = 3'b100,
		rt_offset = 3'b101
	} ddu_reg_type_e;

	typedef enum logic [2:0] {
		ch_a    = 3'b000,
		ch_b    = 3'b001,
		ch_both = 3'b100
	} ddu_chan_e;

	typedef enum logic [2:0] {
		fa_nop   = 3'b000,
		fa_ctrl  = 3'b001,
		fa_clear = 3'b100,
		fa_load  = 3'b101
	} ddu_func_e;

	typedef struct packed {
		logic [4:0]  cnt;
		logic [23:0] shift;
		logic        seq;
	} ddu_link_s;

	typedef struct packed {
		logic [2:0]  sync_pipe;
		logic [2:0]  load_update_n_pipe;
		logic [1:0]  coding_pipe;
		logic [1:0]  chain_pipe;
		logic        seq_seen;
		logic [5:0]  func;
		logic [15:0] in_a;
		logic [15:0] in_b;
		logic [15:0] dac_a;
		logic [15:0] dac_b;
		logic [15:0] coarse_a;
		logic [15:0] coarse_b;
		logic [5:0]  fine_a;
		logic [5:0]  fine_b;
		logic [15:0] offs_a;
		logic [15:0] offs_b;
		logic [23:0] rb_word;
		logic        rb_pend;
		logic [15:0] lad_a;
		logic [15:0] lad_b;
		logic        frame_ok;
		logic        frame_err;
		logic        out_en;
	} ddu_sys_s;

endpackage

// ==== hdl/ddu_serial_port.sv ====
`timescale 1ns/100ps
`include "ddu_regs.svh"

module ddu_serial_port
(
	input  wire logic        clk_sys,
	input  wire logic        srst,
	input  wire logic        link_sclk,
	input  wire logic        frame_sel_n,
	input  wire logic        serial_data_in,
	input  wire logic        load_update_n,
	input  wire logic        coding_select,
	input  wire logic        chain_mode,
	output logic             serial_data_out,
	output logic             serial_out_en,
	output logic [15:0]      dac_code_a,
	output logic [15:0]      dac_code_b,
	output logic [15:0]      ladder_code_a,
	output logic [15:0]      ladder_code_b,
	output logic [4:0]       aux_ctrl,
	output logic             frame_done,
	output logic             frame_error
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hits_a(input logic [2:0] ch);
		hits_a = (ch == ddu_pkg::ch_a) || (ch == ddu_pkg::ch_both);
	endfunction

	function automatic logic hits_b(input logic [2:0] ch);
		hits_b = (ch == ddu_pkg::ch_b) || (ch == ddu_pkg::ch_both);
	endfunction

	// twos complement is turned into the ladder's offset form
	function automatic logic [15:0] to_ladder(input logic [15:0] code, input logic offset_bin);
		to_ladder = offset_bin ? code : (code ^ `DDU_SIGN_FLIP);
	endfunction

	function automatic logic [15:0] read_sel(
		input ddu_pkg::ddu_sys_s st,
		input logic [2:0]        rt,
		input logic [2:0]        ch
	);
		logic use_b;
		use_b = (ch == ddu_pkg::ch_b);
		case (ddu_pkg::ddu_reg_type_e'(rt))
			ddu_pkg::rt_func:   read_sel = {10'h000, st.func};
			ddu_pkg::rt_data:   read_sel = use_b ? st.in_b : st.in_a;
			ddu_pkg::rt_coarse: read_sel = use_b ? st.coarse_b : st.coarse_a;
			ddu_pkg::rt_fine:   read_sel = {10'h000, use_b ? st.fine_b : st.fine_a};
			ddu_pkg::rt_offset: read_sel = use_b ? st.offs_b : st.offs_a;
			default:            read_sel = `DDU_ZERO_CODE;
		endcase
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ddu_pkg::ddu_link_s link_reg;
	ddu_pkg::ddu_link_s link_next;
	ddu_pkg::ddu_sys_s  sys_reg;
	ddu_pkg::ddu_sys_s  sys_next;
	logic               in_frame_reg;
	logic               sdo_reg;
	logic               sdo_next;

	// ------------------------------------------------------------
	// link side, serial clock domain
	// ------------------------------------------------------------
	// rb_word, rb_pend and func are read here quasi-static: the
	// system side only changes them shortly after frame select rises,
	// while the serial clock is quiet between frames
	always_comb
	begin
		link_next = link_reg;
		// edges while frame select is high leave the word alone
		if (!frame_sel_n)
		begin
			if (!in_frame_reg)
			begin
				link_next.seq = ~link_reg.seq;
				link_next.cnt = `DDU_CNT_ONE;
				if (sys_reg.rb_pend)
					link_next.shift = {sys_reg.rb_word[22:0], serial_data_in};
				else
					link_next.shift = {link_reg.shift[22:0], serial_data_in};
			end
			else
			begin
				if (link_reg.cnt != `DDU_CNT_MAX)
					link_next.cnt = link_reg.cnt + `DDU_CNT_ONE;
				link_next.shift = {link_reg.shift[22:0], serial_data_in};
			end
		end
	end

	// reset is taken asynchronously here: the serial clock may stand still
	always_ff @(negedge link_sclk or posedge srst)
	begin
		if (srst)
			link_reg <= '0;
		else
			link_reg <= link_next;
	end

	// marks the first falling edge of each frame
	always_ff @(negedge link_sclk or posedge frame_sel_n)
	begin
		if (frame_sel_n)
			in_frame_reg <= 1'b0;
		else
			in_frame_reg <= 1'b1;
	end

	// ahead of the first falling edge the word to be shifted shows its msb
	always_comb
	begin
		if (sys_reg.func[`DDU_FUNC_OFF])
			sdo_next = 1'b0;
		else if (!in_frame_reg && sys_reg.rb_pend)
			sdo_next = sys_reg.rb_word[23];
		else
			sdo_next = link_reg.shift[23];
	end

	always_ff @(posedge link_sclk or posedge frame_sel_n)
	begin
		if (frame_sel_n)
			sdo_reg <= 1'b0;
		else
			sdo_reg <= sdo_next;
	end

	// ------------------------------------------------------------
	// system side
	// ------------------------------------------------------------
	// shift, cnt and seq are quiet once frame select is high, so they
	// are read after the synchronised rising edge without a handshake
	always_comb
	begin
		logic        frame_end;
		logic        fresh;
		logic        len_ok;
		logic        valid;
		logic        load_update_n_fall;
		logic [23:0] w;
		logic [2:0]  rt;
		logic [2:0]  ch;
		logic [15:0] d;
		frame_end = 1'b0;
		fresh     = 1'b0;
		len_ok    = 1'b0;
		valid     = 1'b0;
		load_update_n_fall = 1'b0;
		w         = link_reg.shift;
		rt        = w[`DDU_REG_HI:`DDU_REG_LO];
		ch        = w[`DDU_CH_HI:`DDU_CH_LO];
		d         = w[`DDU_DATA_HI:0];
		sys_next  = sys_reg;

		sys_next.sync_pipe   = {sys_reg.sync_pipe[1:0], frame_sel_n};
		sys_next.load_update_n_pipe   = {sys_reg.load_update_n_pipe[1:0], load_update_n};
		sys_next.coding_pipe = {sys_reg.coding_pipe[0], coding_select};
		// the chain strap is a pin like the others, so it is synchronised too
		sys_next.chain_pipe  = {sys_reg.chain_pipe[0], chain_mode};
		sys_next.frame_ok    = 1'b0;
		sys_next.frame_err   = 1'b0;

		frame_end = sys_reg.sync_pipe[1] & ~sys_reg.sync_pipe[2];
		load_update_n_fall = sys_reg.load_update_n_pipe[2] & ~sys_reg.load_update_n_pipe[1];

		if (frame_end)
		begin
			// a frame with no clock edge leaves seq untouched
			fresh  = (link_reg.seq != sys_reg.seq_seen);
			len_ok = (link_reg.cnt == `DDU_CNT_FULL) ||
			         (sys_reg.chain_pipe[1] && (link_reg.cnt > `DDU_CNT_FULL));
			valid  = fresh && len_ok && !w[`DDU_BIT_ZERO];
			sys_next.seq_seen = link_reg.seq;
			if (fresh)
				sys_next.rb_pend = 1'b0;
			sys_next.frame_err = ~valid;
			sys_next.frame_ok  = valid;
			if (valid)
			begin
				if (w[`DDU_BIT_RW])
				begin
					sys_next.rb_word = {`DDU_RB_PAD, read_sel(sys_reg, rt, ch)};
					sys_next.rb_pend = 1'b1;
				end
				else
				begin
					case (ddu_pkg::ddu_reg_type_e'(rt))
						ddu_pkg::rt_func:
						begin
							case (ddu_pkg::ddu_func_e'(ch))
								ddu_pkg::fa_nop:
									sys_next.func = sys_reg.func;
								ddu_pkg::fa_ctrl:
									sys_next.func = d[`DDU_FUNC_W-1:0];
								ddu_pkg::fa_clear:
								begin
									sys_next.dac_a = `DDU_ZERO_CODE;
									sys_next.dac_b = `DDU_ZERO_CODE;
								end
								ddu_pkg::fa_load:
								begin
									sys_next.dac_a = sys_reg.in_a;
									sys_next.dac_b = sys_reg.in_b;
								end
								default:
									sys_next.func = sys_reg.func;
							endcase
						end
						ddu_pkg::rt_data:
						begin
							if (hits_a(ch))
							begin
								sys_next.in_a = d;
								if (!sys_reg.load_update_n_pipe[1])
									sys_next.dac_a = d;
							end
							if (hits_b(ch))
							begin
								sys_next.in_b = d;
								if (!sys_reg.load_update_n_pipe[1])
									sys_next.dac_b = d;
							end
						end
						ddu_pkg::rt_coarse:
						begin
							if (hits_a(ch))
								sys_next.coarse_a = d;
							if (hits_b(ch))
								sys_next.coarse_b = d;
						end
						ddu_pkg::rt_fine:
						begin
							if (hits_a(ch))
								sys_next.fine_a = d[`DDU_FINE_W-1:0];
							if (hits_b(ch))
								sys_next.fine_b = d[`DDU_FINE_W-1:0];
						end
						ddu_pkg::rt_offset:
						begin
							if (hits_a(ch))
								sys_next.offs_a = d;
							if (hits_b(ch))
								sys_next.offs_b = d;
						end
						default:
							sys_next.func = sys_reg.func;
					endcase
				end
			end
		end

		// load pin fall copies both input registers, latest values first
		if (load_update_n_fall)
		begin
			sys_next.dac_a = sys_next.in_a;
			sys_next.dac_b = sys_next.in_b;
		end

		sys_next.lad_a = to_ladder(sys_next.dac_a, sys_reg.coding_pipe[1]);
		sys_next.lad_b = to_ladder(sys_next.dac_b, sys_reg.coding_pipe[1]);
		// own flop so the enable pin has no gate behind the register
		sys_next.out_en = ~sys_next.func[`DDU_FUNC_OFF];
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			sys_reg           <= '0;
			sys_reg.sync_pipe <= 3'h7;
			sys_reg.load_update_n_pipe <= 3'h7;
			sys_reg.lad_a     <= `DDU_SIGN_FLIP;
			sys_reg.lad_b     <= `DDU_SIGN_FLIP;
			sys_reg.out_en    <= 1'b1;
		end
		else
			sys_reg <= sys_next;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign serial_data_out = sdo_reg;
	assign serial_out_en   = sys_reg.out_en;
	assign dac_code_a      = sys_reg.dac_a;
	assign dac_code_b      = sys_reg.dac_b;
	assign ladder_code_a   = sys_reg.lad_a;
	assign ladder_code_b   = sys_reg.lad_b;
	assign aux_ctrl        = sys_reg.func[`DDU_AUX_HI:`DDU_AUX_LO];
	assign frame_done      = sys_reg.frame_ok;
	assign frame_error     = sys_reg.frame_err;

endmodule // ddu_serial_port

// ==== tb/ddu_properties.sv ====
`timescale 1ns/100ps
module ddu_properties
(
	input wire logic        clk_sys,
	input wire logic        srst,
	input wire logic        link_sclk,
	input wire logic        frame_sel_n,
	input wire logic        coding_select,
	input wire logic        serial_data_out,
	input wire logic        serial_out_en,
	input wire logic [15:0] dac_code_a,
	input wire logic [15:0] dac_code_b,
	input wire logic [15:0] ladder_code_a,
	input wire logic [4:0]  aux_ctrl,
	input wire logic        frame_done,
	input wire logic        frame_error
);
	// --------------------------------
	// checks
	// --------------------------------
	// saturating age keeps ladder check off the synchroniser fill
	logic [3:0] rst_age;
	always_ff @(posedge clk_sys)
		if (srst)
			rst_age <= 4'h0;
		else if (rst_age != 4'h8)
			rst_age <= rst_age + 4'h1;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_end; $rose(frame_sel_n); endsequence
	sequence s_answer; frame_done || frame_error; endsequence
	property p_answer; s_end |-> ##[2:5] s_answer; endproperty
	property p_pulse; s_answer |-> !(frame_done && frame_error) ##1 !(frame_done || frame_error); endproperty
	property p_err_hold; frame_error |-> $stable(dac_code_a) && $stable(dac_code_b) && $stable(aux_ctrl); endproperty
	property p_ladder; rst_age == 4'h8 |-> ladder_code_a == (coding_select ? dac_code_a : dac_code_a ^ 16'h8000);
	endproperty
	property p_sdo_idle; frame_sel_n && $past(frame_sel_n) |-> !serial_data_out; endproperty
	property p_sdo_off; !serial_out_en |-> !serial_data_out; endproperty
	property p_sdo_edge; !frame_sel_n && $past(!frame_sel_n) && $stable(link_sclk) |-> $stable(serial_data_out);
	endproperty
	property p_rst_val; rst_age == 4'h1 |-> serial_out_en && aux_ctrl == 5'h00 && dac_code_a == 16'h0000; endproperty
	a_answer: assert property (p_answer)
		else $error("frame end without result");
	a_pulse: assert property (p_pulse)
		else $error("result pulse malformed");
	a_err_hold: assert property (p_err_hold)
		else $error("invalid frame changed state");
	a_ladder: assert property (p_ladder)
		else $error("ladder code wrong for coding");
	a_sdo_idle: assert property (p_sdo_idle)
		else $error("serial out not idle");
	a_sdo_off: assert property (p_sdo_off)
		else $error("serial out active while off");
	a_sdo_edge: assert property (p_sdo_edge)
		else $error("serial out moved without rising edge");
	a_rst_val: assert property (p_rst_val)
		else $error("reset values wrong");
endmodule // ddu_properties

// ==== tb/ddu_host_model.sv ====
`timescale 1ns/100ps
module ddu_host_model
(
	output logic        frame_sel_n,
	output logic        link_sclk,
	output logic        serial_data_in,
	input wire logic    serial_data_out,
	output logic [23:0] rx
);
	initial
	begin
		frame_sel_n = 1'b1;
		link_sclk = 1'b0;
		serial_data_in = 1'b0;
		rx = 24'h000000;
	end
	// clock stands low between frames; released data line shows the inverse
	task automatic send(input logic [47:0] w, input int n);
		frame_sel_n = 1'b0;
		#53.7;
		for (int i = n - 1; i >= 0; i--)
		begin
			#80 link_sclk = 1'b1;
			serial_data_in = w[i];
			#80 link_sclk = 1'b0;
			rx = {rx[22:0], serial_data_out};
		end
		#80 frame_sel_n = 1'b1;
		serial_data_in = ~serial_data_in;
	endtask
endmodule // ddu_host_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic        e;
		logic [15:0] a;
		logic [15:0] b;
		logic [4:0]  x;
		logic        c;
		logic [23:0] r;
	} ddu_note_s;
	logic        clk_sys = 1'b0, srst = 1'b1, load_update_n = 1'b1, coding_select = 1'b1, chain_mode = 1'b0;
	logic        link_sclk, frame_sel_n, serial_data_in, serial_data_out, serial_out_en, frame_done, frame_error;
	logic [15:0] dac_code_a, dac_code_b, ladder_code_a, ladder_code_b, d;
	logic [15:0] ea = 16'h0000, eb = 16'h0000;
	logic [4:0]  aux_ctrl, ex = 5'h00;
	logic [23:0] host_rx;
	ddu_note_s   nt;
	ddu_note_s   notes[$];
	int          miscompares = 0, comparisons = 0, cyc = 0;

	ddu_serial_port ddu_serial_port_i (.clk_sys, .srst, .link_sclk, .frame_sel_n, .serial_data_in, .load_update_n,
		.coding_select, .chain_mode, .serial_data_out, .serial_out_en, .dac_code_a, .dac_code_b, .ladder_code_a,
		.ladder_code_b, .aux_ctrl, .frame_done, .frame_error);
	ddu_host_model ddu_host_model_i (.frame_sel_n, .link_sclk, .serial_data_in, .serial_data_out, .rx(host_rx));

	always #5 clk_sys = ~clk_sys;

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic ok);
		comparisons++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("ERROR %0t: output mismatch", $time);
		end
	endtask
	task automatic fr(input logic [47:0] w, input int n = 24, input logic e = 1'b0, input logic c = 1'b0,
		input logic [23:0] r = 24'h000000);
		notes.push_back('{e, ea, eb, ex, c, r});
		ddu_host_model_i.send(w, n);
		step(8);
	endtask
	task automatic rst(input logic cs);
		srst = 1'b1;
		load_update_n = 1'b1;
		coding_select = cs;
		step(2);
		srst = 1'b0;
		step(4);
		load_update_n = 1'b0;
		step(8);
	endtask
	task end_sim;
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(negedge clk_sys)
	begin
		cyc++;
		if (frame_done === 1'b1 || frame_error === 1'b1)
		begin
			chk(notes.size() != 0);
			nt = notes.pop_front();
			chk(frame_error === nt.e && dac_code_a === nt.a && dac_code_b === nt.b && aux_ctrl === nt.x);
			chk(!nt.c || host_rx === nt.r);
		end
		if (cyc == 20000)
		begin
			miscompares++;
			end_sim;
		end
	end

	initial
	begin
		void'($urandom(22));
		rst(1'b1);
		d = 16'($urandom);
		ea = d;
		fr({32'h00000010, d});
		chk(ladder_code_a === d);
		load_update_n = 1'b1;
		d = 16'($urandom);
		fr({32'h00000011, d});
		load_update_n = 1'b0;
		step(8);
		eb = d;
		chk(dac_code_a === ea && dac_code_b === eb);
		load_update_n = 1'b1;
		d = 16'($urandom);
		fr({32'h00000010, d});
		fr({32'h00000011, ~d});
		ea = d;
		eb = ~d;
		fr(48'h050000);
		load_update_n = 1'b0;
		step(8);
		fr(48'h101234, 23, 1'b1);
		fr(48'h101234, 25, 1'b1);
		fr(48'h501234, 24, 1'b1);
		d = 16'($urandom);
		fr({32'h00000020, d});
		fr(48'hA0FFFF);
		fr({32'h00000000, d}, 24, 1'b0, 1'b1, {18'h00000, d[5:0]});
		d = 16'($urandom);
		fr({32'h00000019, d});
		fr(48'h990000);
		fr(48'h000000, 24, 1'b0, 1'b1, {8'h00, d});
		d = 16'($urandom);
		fr({32'h00000028, d});
		fr(48'hA80000);
		fr(48'h000000, 24, 1'b0, 1'b1, {8'h00, d});
		d = 16'($urandom) | 16'h0001;
		ex = d[5:1];
		fr({32'h00000001, d});
		chk(serial_out_en === 1'b0);
		fr(48'hA0FFFF);
		fr(48'h000000, 24, 1'b0, 1'b1, 24'h000000);
		d = d & 16'hFFFE;
		ex = d[5:1];
		fr({32'h00000001, d});
		chk(serial_out_en === 1'b1);
		ea = 16'h0000;
		eb = 16'h0000;
		fr(48'h040000);
		chain_mode = 1'b1;
		d = 16'($urandom);
		ea = d;
		fr({32'hC3A55A10, d}, 48, 1'b0, 1'b1, 24'hC3A55A);
		chain_mode = 1'b0;
		rst(1'b0);
		d = 16'($urandom);
		ea = d;
		eb = d;
		ex = 5'h00;
		fr({32'h00000014, d});
		chk(ladder_code_b === (d ^ 16'h8000));
		end_sim;
	end
endmodule // tb

bind ddu_serial_port ddu_properties ddu_properties_i (.clk_sys, .srst, .link_sclk, .frame_sel_n, .coding_select,
	.serial_data_out, .serial_out_en, .dac_code_a, .dac_code_b, .ladder_code_a, .aux_ctrl, .frame_done, .frame_error);
